// [mcls_pkg.sv]
// Purpose: Shared constants and types for the modem control / line status block
// Assumes: Byte-wide host register port with a 3-bit address
// Notes:   Control register reset value, write mask and field layouts live here

package mcls_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [2:0] MCLS_ADDR_MODEM_INTERFACE_CONTROL = 3'h4;
  localparam logic [2:0] MCLS_ADDR_LINE_CONDITION_STATUS   = 3'h5;

  localparam logic [7:0] MCLS_MIC_RESET      = 8'h00;
  localparam logic [7:0] MCLS_MIC_WRITE_MASK = 8'h1f;
  localparam logic [7:0] MCLS_UNMAPPED_READ  = 8'h00;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] unused;
    logic       local_loopback_select;
    logic       host_irq_output_enable;
    logic       general_output_one;
    logic       rts;
    logic       dtr;
  } mcls_mic_t;

  typedef struct packed {
    logic zero;
    logic transmitter_fully_empty;
    logic hold_empty;
    logic break_flag;
    logic framing_fault_flag;
    logic parity_fault_flag;
    logic overrun_flag;
    logic data_ready;
  } mcls_lcs_t;

  // Receive event from the receiver datapath
  typedef struct packed {
    logic load;
    logic stop_bad;
    logic parity_bad;
    logic break_seen;
  } mcls_rx_evt_t;

  // Modem status lines
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } mcls_modem_t;

endpackage

// [mcls_modem_line.sv]
// Purpose: Modem interface control and line condition status registers
// Assumes: One 10 MHz clock; host strobes are one-cycle pulses, synchronous
// Notes:   Read data is registered and valid the cycle after the read strobe
//
// Behaviour
// - Irq enable set: drive host interrupt pin
// - Irq enable clear: host interrupt pin floats
// - Output one only feeds loopback ring input
// - Writing request-to-send one asserts it
// - Writing request-to-send zero deasserts it
// - Modem control register at address four
// - Eight-bit read-only line status at five
// - Bad stop bit sets framing flag
// - Failed parity check sets parity flag
// - Unread buffer overwritten sets overrun flag

module mcls_modem_line (
  // Clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_rst_n,
  // Host register port
  input  wire logic                  i_cs,
  input  wire logic                  i_rd,
  input  wire logic                  i_wr,
  input  wire logic [2:0]            i_addr,
  input  wire logic [7:0]            i_wdata,
  output logic      [7:0]            o_rdata,
  // Transmit and receive datapath
  input  wire logic                  i_hold_empty,
  input  wire logic                  i_shift_empty,
  input  wire logic                  i_data_ready,
  input  wire mcls_pkg::mcls_rx_evt_t i_rx_evt,
  input  wire logic                  i_tx_serial,
  input  wire logic                  i_rx_serial_pin,
  output logic                       o_rx_serial,
  output logic                       o_loopback,
  // Modem lines
  input  wire mcls_pkg::mcls_modem_t i_modem_pins,
  output mcls_pkg::mcls_modem_t      o_modem_status,
  output logic                       o_rts,
  output logic                       o_dtr,
  // Host interrupt pin
  input  wire logic                  i_irq_request,
  output logic                       o_host_interrupt_pin,
  output logic                       o_host_interrupt_pin_oe
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic mic_wr;
  logic lcs_rd;
  logic any_rd;

  assign any_rd = i_cs & i_rd;
  assign mic_wr = i_cs & i_wr & (i_addr == mcls_pkg::MCLS_ADDR_MODEM_INTERFACE_CONTROL);
  assign lcs_rd = any_rd & (i_addr == mcls_pkg::MCLS_ADDR_LINE_CONDITION_STATUS);

  // ----------------------------------------------------------------
  // Modem interface control register
  // ----------------------------------------------------------------
  mcls_pkg::mcls_mic_t mic_q;
  mcls_pkg::mcls_mic_t mic_d;

  always_comb begin
    mic_d = mic_q;
    if (mic_wr) begin
      mic_d = i_wdata & mcls_pkg::MCLS_MIC_WRITE_MASK;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mic_q <= mcls_pkg::MCLS_MIC_RESET;
    end else begin
      mic_q <= mic_d;
    end
  end

  assign o_rts      = mic_q.rts;
  assign o_dtr      = mic_q.dtr;
  assign o_loopback = mic_q.local_loopback_select;

  // ----------------------------------------------------------------
  // Loopback routing
  // ----------------------------------------------------------------
  // Output one has no pin; it only reaches the ring indicator in loopback
  always_comb begin
    if (mic_q.local_loopback_select) begin
      o_rx_serial            = i_tx_serial;
      o_modem_status.cts     = mic_q.rts;
      o_modem_status.dsr     = mic_q.dtr;
      o_modem_status.ri      = mic_q.general_output_one;
      o_modem_status.dcd     = mic_q.host_irq_output_enable;
    end else begin
      o_rx_serial            = i_rx_serial_pin;
      o_modem_status         = i_modem_pins;
    end
  end

  // ----------------------------------------------------------------
  // Host interrupt pin
  // ----------------------------------------------------------------
  logic irq_q;
  logic irq_d;

  always_comb begin
    irq_d = i_irq_request;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign o_host_interrupt_pin    = irq_q;
  assign o_host_interrupt_pin_oe = mic_q.host_irq_output_enable;

  // ----------------------------------------------------------------
  // Sticky receive error flags
  // ----------------------------------------------------------------
  // Set wins over the clear so an error landing on the read is kept
  logic frame_q, frame_d;
  logic parity_q, parity_d;
  logic oe_q, oe_d;
  logic bi_q, bi_d;

  always_comb begin
    frame_d = lcs_rd ? 1'b0 : frame_q;
    parity_d = lcs_rd ? 1'b0 : parity_q;
    oe_d = lcs_rd ? 1'b0 : oe_q;
    bi_d = lcs_rd ? 1'b0 : bi_q;
    if (i_rx_evt.load) begin
      if (i_rx_evt.stop_bad) begin
        frame_d = 1'b1;
      end
      if (i_rx_evt.parity_bad) begin
        parity_d = 1'b1;
      end
      if (i_data_ready) begin
        oe_d = 1'b1;
      end
      if (i_rx_evt.break_seen) begin
        bi_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_q <= 1'b0;
      parity_q <= 1'b0;
      oe_q <= 1'b0;
      bi_q <= 1'b0;
    end else begin
      frame_q <= frame_d;
      parity_q <= parity_d;
      oe_q <= oe_d;
      bi_q <= bi_d;
    end
  end

  // ----------------------------------------------------------------
  // Line condition status and read data
  // ----------------------------------------------------------------
  mcls_pkg::mcls_lcs_t lcs;
  logic [7:0]          rdata_q;
  logic [7:0]          rdata_d;

  always_comb begin
    lcs.zero                    = 1'b0;
    lcs.transmitter_fully_empty = i_hold_empty & i_shift_empty;
    lcs.hold_empty              = i_hold_empty;
    lcs.break_flag              = bi_q;
    lcs.framing_fault_flag      = frame_q;
    lcs.parity_fault_flag       = parity_q;
    lcs.overrun_flag            = oe_q;
    lcs.data_ready              = i_data_ready;
  end

  always_comb begin
    rdata_d = rdata_q;
    if (any_rd) begin
      case (i_addr)
        mcls_pkg::MCLS_ADDR_MODEM_INTERFACE_CONTROL: rdata_d = mic_q;
        mcls_pkg::MCLS_ADDR_LINE_CONDITION_STATUS:   rdata_d = lcs;
        default:                                     rdata_d = mcls_pkg::MCLS_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  chk_irq_drive_on: assert property (mic_wr && i_wdata[3] |=> o_host_interrupt_pin_oe)
    else $error("irq pin not driven while enabled");
  chk_irq_float_off: assert property (mic_wr && !i_wdata[3] |=> !o_host_interrupt_pin_oe)
    else $error("irq pin driven while disabled");
  // The pin register still holds its reset value at the first edge out of reset
  chk_irq_follows: assert property ($past(i_rst_n) |-> o_host_interrupt_pin == $past(i_irq_request))
    else $error("irq pin does not follow request");
  chk_general_output_one_ring_loop: assert property (o_loopback |-> o_modem_status.ri == mic_q.general_output_one)
    else $error("output one not looped to ring");
  chk_general_output_one_no_effect: assert property (!o_loopback |-> o_modem_status == i_modem_pins)
    else $error("modem status not from pins outside loopback");
  chk_rts_set: assert property (mic_wr && i_wdata[1] |=> o_rts && (!o_loopback || o_modem_status.cts))
    else $error("rts not asserted after write one");
  chk_rts_clear: assert property (mic_wr && !i_wdata[1] |=> !o_rts)
    else $error("rts not cleared after write zero");
  chk_mic_readback: assert property (any_rd && (i_addr == mcls_pkg::MCLS_ADDR_MODEM_INTERFACE_CONTROL)
      |=> o_rdata == {3'h0, $past(mic_q[4:0])})
    else $error("control register readback wrong");
  chk_lcs_read: assert property (lcs_rd |=> o_rdata[7] == 1'b0 && o_rdata[6] == $past(i_hold_empty & i_shift_empty))
    else $error("status read wrong");
  chk_loop_serial: assert property (o_loopback |-> o_rx_serial == i_tx_serial)
    else $error("loopback serial path broken");
  chk_frame_set: assert property (i_rx_evt.load && i_rx_evt.stop_bad |=> frame_q)
    else $error("framing flag not set");
  chk_parity_set: assert property (i_rx_evt.load && i_rx_evt.parity_bad |=> parity_q)
    else $error("parity flag not set");
  chk_oe_set: assert property (i_rx_evt.load && i_data_ready |=> oe_q)
    else $error("overrun flag not set");
  chk_flag_clear: assert property (lcs_rd && !i_rx_evt.load |=> !frame_q && !parity_q && !oe_q)
    else $error("flags not cleared by status read");

  cov_loopback: cover property (mic_wr && i_wdata[4] ##1 o_loopback);
  cov_overrun_read: cover property (oe_q ##1 lcs_rd ##1 !oe_q);
  cov_set_on_clear: cover property (lcs_rd && i_rx_evt.load && i_rx_evt.stop_bad);

endmodule

// [mcls_host_model.sv]
// Purpose: Host processor model on the byte-wide register port
// Assumes: Strobes change 1 ns after a rising edge, one cycle each
// Notes:   Released address and data show the inverse of the last value
module mcls_host_model (
  // Clock and read data
  input  wire logic       i_clock,
  input  wire logic [7:0] i_rdata,
  // Register port
  output logic            o_cs,
  output logic            o_rd,
  output logic            o_wr,
  output logic      [2:0] o_addr,
  output logic      [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_cs = 1'b0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = 3'h0;
    o_wdata = 8'h00;
  end
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic cycle(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clock);
    #1;
    o_cs = 1'b1;
    o_wr = w;
    o_rd = ~w;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clock);
    #1;
    o_cs = 1'b0;
    o_wr = 1'b0;
    o_rd = 1'b0;
    // Stale values would hide a decode that ignores the strobes
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    cycle(1'b1, a, d);
  endtask
  task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
    cycle(1'b0, a, 8'h00);
    d = i_rdata;
  endtask
endmodule

// [modem_control_line_status_tb.sv]
// Purpose: Self-checking bench for the modem control / line status block
// Assumes: 10 MHz clock, inputs change 1 ns after the rising edge
// Notes:   Expected values are built from the register layouts
module modem_control_line_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  i_clock, i_rst_n, cs, rd, wr, hold_e, shift_e, dr;
  logic                  tx_s, rx_pin, irq, rts, dtr, lb, rx_s, pin, pin_oe;
  logic [2:0]            addr;
  logic [7:0]            wdata, rdata, v;
  mcls_pkg::mcls_rx_evt_t evt;
  mcls_pkg::mcls_modem_t pins, mstat;
  int                    n_errors, n_compared;
  mcls_host_model mcls_host_model_i (.i_clock(i_clock), .i_rdata(rdata), .o_cs(cs),
    .o_rd(rd), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
  mcls_modem_line mcls_modem_line_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_cs(cs),
    .i_rd(rd), .i_wr(wr), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .i_hold_empty(hold_e), .i_shift_empty(shift_e), .i_data_ready(dr), .i_rx_evt(evt),
    .i_tx_serial(tx_s), .i_rx_serial_pin(rx_pin), .o_rx_serial(rx_s), .o_loopback(lb),
    .i_modem_pins(pins), .o_modem_status(mstat), .o_rts(rts), .o_dtr(dtr),
    .i_irq_request(irq), .o_host_interrupt_pin(pin), .o_host_interrupt_pin_oe(pin_oe));
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    mcls_host_model_i.read_reg(a, v);
    check(v, exp);
  endtask
  // Event, then a read that clears sticky flags, then a read after clearing
  task automatic rx_ck(input logic [3:0] e, input logic [7:0] exp);
    @(posedge i_clock);
    #1;
    evt = e;
    @(posedge i_clock);
    #1;
    evt = 4'h0;
    rd_chk(3'h5, exp);
    rd_chk(3'h5, exp & 8'he1);
  endtask
  initial begin
    repeat (20000) @(posedge i_clock);
    n_errors++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    // Both transmit registers empty, no unread byte, request high, rx pin opposite tx
    {i_rst_n, hold_e, shift_e, dr, tx_s, rx_pin, irq, evt, pins} = {7'h33, 4'h0, 4'h3};
    n_errors = 0;
    n_compared = 0;
    repeat (5) @(posedge i_clock);
    #1;
    i_rst_n = 1'b1;
    rd_chk(3'h4, 8'h00);
    check({6'h0, pin_oe, rts}, 8'h00);
    mcls_host_model_i.write_reg(3'h4, 8'h02);
    check({7'h0, rts}, 8'h01);
    rd_chk(3'h4, 8'h02);
    mcls_host_model_i.write_reg(3'h4, 8'h00);
    check({7'h0, rts}, 8'h00);
    mcls_host_model_i.write_reg(3'h4, 8'h04);
    check({rts, dtr, pin_oe, lb, mstat}, {4'h0, pins});
    mcls_host_model_i.write_reg(3'h4, 8'hff);
    check({5'h0, lb, rts, dtr}, 8'h07);
    rd_chk(3'h4, 8'h1f);
    check({3'h0, rx_s, mstat}, {3'h0, tx_s, 4'hf});
    mcls_host_model_i.write_reg(3'h4, 8'h16);
    check({3'h0, rx_s, mstat}, {3'h0, tx_s, 4'h5});
    check({7'h0, pin_oe}, 8'h00);
    mcls_host_model_i.write_reg(3'h4, 8'h08);
    check({6'h0, pin_oe, pin}, 8'h03);
    irq = 1'b0;
    check({7'h0, pin}, 8'h01);
    @(posedge i_clock);
    #1;
    check({7'h0, pin}, 8'h00);
    mcls_host_model_i.write_reg(3'h4, 8'h00);
    check({6'h0, pin_oe, rx_s}, {7'h0, rx_pin});
    rd_chk(3'h5, 8'h60);
    mcls_host_model_i.write_reg(3'h5, 8'hff);
    rd_chk(3'h5, 8'h60);
    shift_e = 1'b0;
    rd_chk(3'h5, 8'h20);
    {hold_e, shift_e} = 2'b01;
    rd_chk(3'h5, 8'h00);
    hold_e = 1'b1;
    rx_ck(4'hc, 8'h68);
    rx_ck(4'ha, 8'h64);
    rx_ck(4'h9, 8'h70);
    rx_ck(4'h8, 8'h60);
    dr = 1'b1;
    rx_ck(4'h8, 8'h63);
    dr = 1'b0;
    // Bad stop bit lands on the status read itself: the set must survive
    fork
      rd_chk(3'h5, 8'h60);
      begin
        @(posedge i_clock);
        #1;
        evt = 4'hc;
        @(posedge i_clock);
        #1;
        evt = 4'h0;
      end
    join
    rd_chk(3'h5, 8'h68);
    rd_chk(3'h7, 8'h00);
    mcls_host_model_i.write_reg(3'h4, 8'h0b);
    check({5'h0, pin_oe, rts, dtr}, 8'h07);
    @(posedge i_clock);
    #1;
    i_rst_n = 1'b0;
    @(posedge i_clock);
    #1;
    check({5'h0, pin_oe, rts, dtr}, 8'h00);
    i_rst_n = 1'b1;
    rd_chk(3'h4, 8'h00);
    complete_run();
  end
endmodule
